//--- fifo_part_pkg.sv
package fifo_part_pkg;
  // ==========================================
  // register map
  localparam logic [7:0] CONFIG_OFFSET = 8'h74;
  localparam int TXSZ_LSB = 16;
  localparam int TXSZ_W = 4;
  localparam int STRAP_BIT = 2;
  localparam int TMO_BIT = 1;
  localparam int TRIG_BIT = 0;
  localparam logic [3:0] TXSZ_RESET = 4'h5;
  localparam logic [3:0] TXSZ_MIN = 4'h2;
  localparam logic [3:0] TXSZ_MAX = 4'he;
  // ==========================================
  // memory partitioning, sizes in bytes
  localparam logic [15:0] TOTAL_BYTES = 16'h4000;
  localparam int KB_SHIFT = 10;
  localparam logic [15:0] TXS_BYTES = 16'h0200;
  localparam int RXS_SHIFT = 4;
  localparam logic [15:0] FULL_MARGIN_BYTES = 16'h0010;
  localparam logic [15:0] WORD_BYTES = 16'h0008;
  // ==========================================
  // mac-side buffers, 8-byte words
  localparam int WORD_W = 64;
  localparam int TX_BUF_DEPTH = 256;
  localparam int RX_BUF_DEPTH = 16;
  localparam logic [1:0] BUF_MAX_FRAMES = 2'h2;
endpackage

//--- fifo_partition.sv
// Contract
// - bit 2 reads strapped bus width
// - reset without phy clocks sets time-out
// - writes ignored until first read
// - size setting covers whole transmit allocation
// - transmit status always 512 bytes
// - transmit data holds commands and payload
// - receive allocation is 16384 minus transmit
// - receive status is one sixteenth
// - receive data full 4 dwords early
// - fixed 2k and 128 byte mac buffers
// - mac transmit buffer refills, two frames
// - receive data collects while fifo full
// - overrun drops frames, counts each once
// - mac buffer levels hidden from host

// ==========================================
// synchronous fifo
module stream_fifo #(
  parameter int WIDTH = 65,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage has no reset, so it maps onto ram
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr_reg] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else if (clear) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ==========================================
// partition, mac-side buffers and soft reset
module fifo_partition
  import fifo_part_pkg::*;
(
  // clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  // register port
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [31:0] REG_RDATA_OUT,
  // straps and phy state
  input wire logic BUS_WIDTH_STRAP_IN,
  input wire logic PHY_CLOCKS_RUNNING_IN,
  output logic SOFT_RESET_OUT,
  // partition sizes in bytes
  output logic [15:0] TX_DATA_SIZE_OUT,
  output logic [15:0] TX_STATUS_SIZE_OUT,
  output logic [15:0] RX_DATA_SIZE_OUT,
  output logic [15:0] RX_STATUS_SIZE_OUT,
  // transmit data fifo side
  input wire logic [WORD_W-1:0] TXD_DATA_IN,
  input wire logic TXD_LAST_IN,
  input wire logic TXD_VALID_IN,
  output logic TXD_READY_OUT,
  // mac transmit side
  output logic [WORD_W-1:0] MAC_TX_DATA_OUT,
  output logic MAC_TX_LAST_OUT,
  output logic MAC_TX_VALID_OUT,
  input wire logic MAC_TX_READY_IN,
  // mac receive side, cannot stall
  input wire logic [WORD_W-1:0] MAC_RX_DATA_IN,
  input wire logic MAC_RX_LAST_IN,
  input wire logic MAC_RX_VALID_IN,
  // receive data fifo side
  output logic [WORD_W-1:0] RXD_DATA_OUT,
  output logic RXD_LAST_OUT,
  output logic RXD_VALID_OUT,
  input wire logic RXD_READY_IN,
  input wire logic RXD_FREE_IN,
  output logic [15:0] RX_DATA_USED_OUT,
  output logic RX_DATA_FULL_OUT,
  output logic [31:0] RX_DROP_COUNT_OUT
);
  logic [3:0] size_reg;
  logic strap_reg;
  logic strap_cap_reg;
  logic tmo_reg;
  logic read_seen_reg;
  logic soft_rst_reg;
  logic [31:0] rdata_reg;
  logic [15:0] txd_size_reg;
  logic [15:0] rxd_size_reg;
  logic [15:0] rxs_size_reg;
  logic [15:0] rx_used_reg;
  logic [31:0] drop_cnt_reg;
  logic rx_in_frame_reg;
  logic rx_drop_frame_reg;
  logic rx_drop_mode_reg;
  logic tx_in_frame_reg;
  logic [1:0] tx_frames_reg;
  logic hit;
  logic wr_ok;
  logic trig_req;
  logic [15:0] tx_total;
  logic [15:0] rx_total;
  logic rxd_full;
  logic rx_start;
  logic discard_now;
  logic overrun;
  logic lose_first;
  logic rxm_in_ready;
  logic rxm_out_valid;
  logic rxd_write;
  logic tx_blocked;
  logic txm_in_ready;
  logic tx_push;
  logic tx_pop;
  logic [WORD_W:0] rxm_out;
  logic [WORD_W:0] txm_out;

  // ==========================================
  // register port
  assign hit = (REG_ADDR_IN == CONFIG_OFFSET);
  assign wr_ok = REG_WR_IN && read_seen_reg;
  assign trig_req = wr_ok && hit && REG_WDATA_IN[TRIG_BIT];

  // bus width strap caught once after reset release
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      strap_reg <= 1'b0;
      strap_cap_reg <= 1'b0;
    end else if (!strap_cap_reg) begin
      strap_reg <= BUS_WIDTH_STRAP_IN;
      strap_cap_reg <= 1'b1;
    end
  end

  // write gate: bus may not be settled until the host has read once
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      read_seen_reg <= 1'b0;
    end else if (REG_RD_IN) begin
      read_seen_reg <= 1'b1;
    end else if (soft_rst_reg) begin
      read_seen_reg <= 1'b0;
    end
  end

  // soft reset trigger; without phy clocks it cannot finish
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      soft_rst_reg <= 1'b0;
      tmo_reg <= 1'b0;
    end else begin
      soft_rst_reg <= trig_req && PHY_CLOCKS_RUNNING_IN;
      if (trig_req && !PHY_CLOCKS_RUNNING_IN) begin
        tmo_reg <= 1'b1;
      end else if (soft_rst_reg) begin
        tmo_reg <= 1'b0;
      end
    end
  end

  // partition size; reserved values are stored as written
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      size_reg <= TXSZ_RESET;
    end else if (soft_rst_reg) begin
      size_reg <= TXSZ_RESET;
    end else if (wr_ok && hit) begin
      size_reg <= REG_WDATA_IN[TXSZ_LSB +: TXSZ_W];
    end
  end

  // read data, trigger bit always reads zero
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdata_reg <= '0;
    end else if (REG_RD_IN) begin
      rdata_reg <= '0;
      if (hit) begin
        rdata_reg[TXSZ_LSB +: TXSZ_W] <= size_reg;
        rdata_reg[STRAP_BIT] <= strap_reg;
        rdata_reg[TMO_BIT] <= tmo_reg;
      end
    end
  end

  assign REG_RDATA_OUT = rdata_reg;
  assign SOFT_RESET_OUT = soft_rst_reg;

  // ==========================================
  // partition sizes
  assign tx_total = 16'(size_reg) << KB_SHIFT;
  assign rx_total = TOTAL_BYTES - tx_total;

  // registered so the full compare sees a steady size
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      txd_size_reg <= '0;
      rxd_size_reg <= '0;
      rxs_size_reg <= '0;
    end else begin
      txd_size_reg <= tx_total - TXS_BYTES;
      rxs_size_reg <= rx_total >> RXS_SHIFT;
      rxd_size_reg <= rx_total - (rx_total >> RXS_SHIFT);
    end
  end

  assign TX_DATA_SIZE_OUT = txd_size_reg;
  assign TX_STATUS_SIZE_OUT = TXS_BYTES;
  assign RX_DATA_SIZE_OUT = rxd_size_reg;
  assign RX_STATUS_SIZE_OUT = rxs_size_reg;

  // ==========================================
  // transmit mac-side buffer, 2k bytes
  assign tx_blocked = !tx_in_frame_reg && (tx_frames_reg >= BUF_MAX_FRAMES);
  assign TXD_READY_OUT = txm_in_ready && !tx_blocked;
  assign tx_push = TXD_VALID_IN && TXD_READY_OUT;
  assign tx_pop = MAC_TX_VALID_OUT && MAC_TX_READY_IN;

  stream_fifo #(.WIDTH(WORD_W+1), .DEPTH(TX_BUF_DEPTH)) tx_buf (
    .clk(CLOCK_IN),
    .rst(RST_IN),
    .clear(soft_rst_reg),
    .in_data({TXD_LAST_IN, TXD_DATA_IN}),
    .in_valid(TXD_VALID_IN && !tx_blocked),
    .in_ready(txm_in_ready),
    .out_data(txm_out),
    .out_valid(MAC_TX_VALID_OUT),
    .out_ready(MAC_TX_READY_IN)
  );

  assign MAC_TX_DATA_OUT = txm_out[WORD_W-1:0];
  assign MAC_TX_LAST_OUT = txm_out[WORD_W];

  // frames started in the buffer and not yet fully sent
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tx_in_frame_reg <= 1'b0;
      tx_frames_reg <= '0;
    end else if (soft_rst_reg) begin
      tx_in_frame_reg <= 1'b0;
      tx_frames_reg <= '0;
    end else begin
      if (tx_push) begin
        tx_in_frame_reg <= !TXD_LAST_IN;
      end
      if (tx_push && !tx_in_frame_reg && !(tx_pop && MAC_TX_LAST_OUT)) begin
        tx_frames_reg <= tx_frames_reg + 1'b1;
      end else if (!(tx_push && !tx_in_frame_reg) && tx_pop && MAC_TX_LAST_OUT) begin
        tx_frames_reg <= tx_frames_reg - 1'b1;
      end
    end
  end

  // ==========================================
  // receive mac-side buffer, 128 bytes
  assign rxd_full = (rx_used_reg + FULL_MARGIN_BYTES) >= rxd_size_reg;
  assign rx_start = MAC_RX_VALID_IN && !rx_in_frame_reg;
  assign discard_now = rx_start ? (rx_drop_mode_reg && rxd_full) : rx_drop_frame_reg;
  assign overrun = MAC_RX_VALID_IN && !discard_now && !rxm_in_ready;
  assign lose_first = MAC_RX_VALID_IN && (discard_now || overrun) && !rx_drop_frame_reg;

  stream_fifo #(.WIDTH(WORD_W+1), .DEPTH(RX_BUF_DEPTH)) rx_buf (
    .clk(CLOCK_IN),
    .rst(RST_IN),
    .clear(soft_rst_reg),
    .in_data({MAC_RX_LAST_IN, MAC_RX_DATA_IN}),
    .in_valid(MAC_RX_VALID_IN && !discard_now),
    .in_ready(rxm_in_ready),
    .out_data(rxm_out),
    .out_valid(rxm_out_valid),
    .out_ready(RXD_READY_IN && !rxd_full)
  );

  // hold words in the mac buffer while the data fifo is full
  assign RXD_VALID_OUT = rxm_out_valid && !rxd_full;
  assign RXD_DATA_OUT = rxm_out[WORD_W-1:0];
  assign RXD_LAST_OUT = rxm_out[WORD_W];
  assign rxd_write = RXD_VALID_OUT && RXD_READY_IN;

  // frame tracking and drop decision; a frame cut by an overrun is
  // left without its end marker, the status path must flag it
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rx_in_frame_reg <= 1'b0;
      rx_drop_frame_reg <= 1'b0;
      rx_drop_mode_reg <= 1'b0;
    end else if (soft_rst_reg) begin
      rx_in_frame_reg <= 1'b0;
      rx_drop_frame_reg <= 1'b0;
      rx_drop_mode_reg <= 1'b0;
    end else begin
      if (MAC_RX_VALID_IN) begin
        rx_in_frame_reg <= !MAC_RX_LAST_IN;
        rx_drop_frame_reg <= !MAC_RX_LAST_IN && (discard_now || overrun);
      end
      if (overrun) begin
        rx_drop_mode_reg <= 1'b1;
      end else if (!rxd_full) begin
        rx_drop_mode_reg <= 1'b0;
      end
    end
  end

  // lost frame counter
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      drop_cnt_reg <= '0;
    end else if (soft_rst_reg) begin
      drop_cnt_reg <= '0;
    end else if (lose_first) begin
      drop_cnt_reg <= drop_cnt_reg + 1'b1;
    end
  end

  // host-visible level counts only words in the data fifo
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rx_used_reg <= '0;
    end else if (soft_rst_reg) begin
      rx_used_reg <= '0;
    end else if (rxd_write && !RXD_FREE_IN) begin
      rx_used_reg <= rx_used_reg + WORD_BYTES;
    end else if (!rxd_write && RXD_FREE_IN && rx_used_reg >= WORD_BYTES) begin
      rx_used_reg <= rx_used_reg - WORD_BYTES;
    end
  end

  assign RX_DATA_USED_OUT = rx_used_reg;
  assign RX_DATA_FULL_OUT = rxd_full;
  assign RX_DROP_COUNT_OUT = drop_cnt_reg;

  // ==========================================
  // checks
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);

  sequence s_trig_ok;
    trig_req && PHY_CLOCKS_RUNNING_IN;
  endsequence
  sequence s_trig_done;
    soft_rst_reg ##1 (size_reg == TXSZ_RESET && !read_seen_reg && !tmo_reg);
  endsequence

  chk_strap_readback: assert property (REG_RD_IN && hit && strap_cap_reg |=>
    REG_RDATA_OUT[STRAP_BIT] == strap_reg && REG_RDATA_OUT[TRIG_BIT] == 1'b0)
    else $error("strap readback wrong");
  chk_timeout_set: assert property (trig_req && !PHY_CLOCKS_RUNNING_IN |=>
    tmo_reg && !soft_rst_reg)
    else $error("time-out flag not set");
  chk_soft_reset_seq: assert property ((s_trig_ok and !REG_RD_IN) |=> s_trig_done)
    else $error("soft reset did not clear state");
  chk_write_gate: assert property (REG_WR_IN && hit && !read_seen_reg |=>
    $stable(size_reg))
    else $error("write taken before read");
  chk_tx_partition: assert property (1'b1 |=>
    txd_size_reg == ({2'h0, $past(size_reg), 10'h000} - 16'h0200))
    else $error("tx data size wrong");
  chk_rx_partition: assert property (1'b1 |=>
    rxd_size_reg + rxs_size_reg == 16'h4000 - {2'h0, $past(size_reg), 10'h000})
    else $error("rx sizes wrong");
  chk_rxd_full_edge: assert property (rx_used_reg + 16'h0010 < rxd_size_reg |->
    !rxd_full)
    else $error("rx full too early");
  chk_rx_hold: assert property (rxd_full |-> !RXD_VALID_OUT)
    else $error("write into full rx fifo");
  chk_buf_frames: assert property (tx_frames_reg <= 2'h2)
    else $error("too many frames in tx buffer");
  chk_drop_count: assert property (lose_first && !soft_rst_reg |=>
    drop_cnt_reg == $past(drop_cnt_reg) + 32'h1)
    else $error("lost frame not counted");
endmodule

//--- host_model.sv
// ==========================================
// host processor on the register port
module host_model
  import fifo_part_pkg::*;
(
  input wire logic clk_in,
  output logic [7:0] addr_out,
  output logic [31:0] wdata_out,
  output logic wr_out,
  output logic rd_out,
  input wire logic [31:0] rdata_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle bus at time zero, strobes low
  initial begin
    addr_out = 8'h00;
    wdata_out = 32'h0;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // one strobe cycle, launched on the falling edge so the rising edge sees it settled
  task automatic access(input logic is_wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rv);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = is_wr;
    rd_out = !is_wr;
    @(negedge clk_in);
    wr_out = 1'b0;
    rd_out = 1'b0;
    // read data is registered, so give it the edge after the strobe
    @(negedge clk_in);
    rv = rdata_in;
  endtask
  // every session opens with a read, otherwise writes are dropped
  task automatic rd_cfg(output logic [31:0] rv);
    access(1'b0, CONFIG_OFFSET, 32'h0, rv);
  endtask
  // callers pass only sizes 2..14; t_soft_reset also triggers once with phy clocks stopped
  task automatic wr_cfg(input logic [3:0] sz, input logic trig);
    logic [31:0] dummy;
    access(1'b1, CONFIG_OFFSET, {12'h0, sz, 15'h0, trig}, dummy);
  endtask
endmodule

//--- tb_top.sv
// ==========================================
// bench for partitioning, mac buffers and soft reset
module tb_top
  import fifo_part_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, strap = 1'b1, phy_run = 1'b1;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rv, drops;
  logic wr, rd, soft_rst, txd_last = 1'b0, txd_valid = 1'b0, txd_ready, mtx_last, mtx_valid;
  logic mrx_last = 1'b1;
  logic mtx_ready = 1'b0, mrx_valid = 1'b0, rxd_last, rxd_valid, rxd_free = 1'b0, rxd_full;
  logic [15:0] txd_sz, txs_sz, rxd_sz, rxs_sz, used;
  logic [63:0] txd_data = 64'h0, mtx_data, rxd_data;
  int err_count = 0, compares = 0, pulses = 0;
  // 100 ns period
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (soft_rst === 1'b1) pulses++;
  end
  host_model u_host (.clk_in(clk), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
    .rd_out(rd), .rdata_in(rdata));
  fifo_partition u_dut (.CLOCK_IN(clk), .RST_IN(rst), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
    .BUS_WIDTH_STRAP_IN(strap), .PHY_CLOCKS_RUNNING_IN(phy_run), .SOFT_RESET_OUT(soft_rst),
    .TX_DATA_SIZE_OUT(txd_sz), .TX_STATUS_SIZE_OUT(txs_sz), .RX_DATA_SIZE_OUT(rxd_sz),
    .RX_STATUS_SIZE_OUT(rxs_sz), .TXD_DATA_IN(txd_data), .TXD_LAST_IN(txd_last),
    .TXD_VALID_IN(txd_valid), .TXD_READY_OUT(txd_ready), .MAC_TX_DATA_OUT(mtx_data),
    .MAC_TX_LAST_OUT(mtx_last), .MAC_TX_VALID_OUT(mtx_valid), .MAC_TX_READY_IN(mtx_ready),
    .MAC_RX_DATA_IN(64'h00c0_ffee_0000_0001), .MAC_RX_LAST_IN(mrx_last),
    .MAC_RX_VALID_IN(mrx_valid), .RXD_DATA_OUT(rxd_data), .RXD_LAST_OUT(rxd_last),
    .RXD_VALID_OUT(rxd_valid), .RXD_READY_IN(1'b1), .RXD_FREE_IN(rxd_free),
    .RX_DATA_USED_OUT(used), .RX_DATA_FULL_OUT(rxd_full), .RX_DROP_COUNT_OUT(drops));
  // ==========================================
  // shared checking
  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one mac receive word per call, a full frame unless the caller holds mrx_last low
  task automatic rx_word();
    @(negedge clk);
    mrx_valid = 1'b1;
    @(negedge clk);
    mrx_valid = 1'b0;
  endtask
  // ==========================================
  // scenarios
  task automatic t_first_read();
    u_host.wr_cfg(4'h8, 1'b0);
    u_host.rd_cfg(rv);
    chk("cfg after reset", {44'h0, TXSZ_RESET, 13'h0, 3'b100}, {32'h0, rv});
    $display("first read test done");
  endtask
  task automatic t_sizes();
    logic [15:0] rx_all;
    for (int n = 2; n <= 14; n++) begin
      u_host.wr_cfg(4'(n), 1'b0);
      rx_all = 16'h4000 - 16'(n * 1024);
      chk("tx data size", 64'(n * 1024 - 512), {48'h0, txd_sz});
      chk("tx status size", 64'h200, {48'h0, txs_sz});
      chk("rx status size", {48'h0, rx_all >> 4}, {48'h0, rxs_sz});
      chk("rx data size", {48'h0, rx_all - (rx_all >> 4)}, {48'h0, rxd_sz});
    end
    $display("size table test done");
  endtask
  task automatic t_soft_reset();
    int p0;
    p0 = pulses;
    phy_run = 1'b0;
    u_host.wr_cfg(4'h9, 1'b1);
    u_host.rd_cfg(rv);
    chk("time-out flag", 64'h1, {63'h0, rv[1]});
    chk("no pulse", 64'(p0), 64'(pulses));
    @(negedge clk);
    phy_run = 1'b1;
    u_host.wr_cfg(4'h9, 1'b1);
    u_host.rd_cfg(rv);
    chk("cfg after soft reset", {44'h0, TXSZ_RESET, 13'h0, 3'b100}, {32'h0, rv});
    chk("one pulse", 64'(p0 + 1), 64'(pulses));
    $display("soft reset test done");
  endtask
  task automatic t_tx();
    for (int f = 0; f < 3; f++) begin
      @(negedge clk);
      txd_data = 64'(f + 'h10);
      txd_last = 1'b1;
      txd_valid = (f < 2);
      if (f == 2) chk("third frame held", 64'h0, {63'h0, txd_ready});
    end
    @(negedge clk);
    txd_valid = 1'b0;
    chk("mac head", 64'h10, mtx_data);
    chk("mac valid", 64'h1, {63'h0, mtx_valid});
    chk("mac last", 64'h1, {63'h0, mtx_last});
    mtx_ready = 1'b1;
    @(negedge clk);
    mtx_ready = 1'b0;
    chk("space refills", 64'h1, {63'h0, txd_ready});
    chk("second frame", 64'h11, mtx_data);
    $display("transmit test done");
  endtask
  task automatic t_rx();
    int k;
    u_host.wr_cfg(4'he, 1'b0);
    k = 0;
    while (rxd_full !== 1'b1) begin
      rx_word();
      repeat (2) @(negedge clk);
      k++;
      if (k > 300) begin
        chk("rx fill bound", 64'h0, 64'h1);
        return;
      end
    end
    chk("used at full", {48'h0, rxd_sz - 16'h10}, {48'h0, used});
    for (int w = 0; w < 19; w++) rx_word();
    repeat (2) @(negedge clk);
    chk("held back", 64'h0, {63'h0, rxd_valid});
    chk("dropped frames", 64'h3, {32'h0, drops});
    chk("used excludes mac", {48'h0, rxd_sz - 16'h10}, {48'h0, used});
    chk("held data", 64'h00c0_ffee_0000_0001, rxd_data);
    chk("held last", 64'h1, {63'h0, rxd_last});
    // a three-word frame arriving while dropping is counted once
    mrx_last = 1'b0;
    rx_word();
    rx_word();
    mrx_last = 1'b1;
    rx_word();
    repeat (2) @(negedge clk);
    chk("long frame dropped once", 64'h4, {32'h0, drops});
    @(negedge clk);
    rxd_free = 1'b1;
    @(negedge clk);
    rxd_free = 1'b0;
    repeat (2) @(negedge clk);
    rx_word();
    repeat (2) @(negedge clk);
    chk("count after free", 64'h4, {32'h0, drops});
    $display("receive test done");
  endtask
  // ==========================================
  // main sequence, reset held for 3 cycles
  initial begin
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    t_first_read();
    t_sizes();
    t_soft_reset();
    t_tx();
    t_rx();
    test_done();
  end
endmodule
